// ===== cog_fall_cfg.svh
`ifndef COG_FALL_CFG_SVH
`define COG_FALL_CFG_SVH

// Register byte addresses
`define ADDR_FALL_EN     8'h00
`define ADDR_FALL_MODE   8'h04
`define ADDR_SD_CTRL     8'h08
`define ADDR_SD_SRC_EN   8'h0C
`define ADDR_POLARITY    8'h10
`define ADDR_PHASE       8'h14
`define ADDR_IRQ_STAT    8'h18
`define ADDR_IRQ_MASK    8'h1C

// Shutdown control fields
`define SD_STATUS_BIT    7
`define SD_RESTART_BIT   6
`define SD_BD_HI         5
`define SD_BD_LO         4
`define SD_AC_HI         3
`define SD_AC_LO         2
`define SD_CTRL_IMPL     8'hFC

// Override level codes
`define OVR_HIGH         2'h3
`define OVR_LOW          2'h2
`define OVR_HIZ          2'h1
`define OVR_INACTIVE     2'h0

// Interrupt status bits
`define IRQ_FALL_BIT     0
`define IRQ_SD_BIT       1

// Reset values
`define RST_BYTE         8'h00
`define RST_NIB          4'h0
`define RST_PHASE        6'h00

// AXI responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ===== cog_fall_pkg.sv
`default_nettype none
package cog_fall_pkg;
    typedef enum logic [0:0] {DLY_IDLE, DLY_RUN} dly_state_t;
    typedef struct packed {
        logic [3:0] level;  // d c b a
        logic [3:0] oe;
    } pin_drive_t;
endpackage
`default_nettype wire

// ===== cog_fall_shutdown.sv
`include "cog_fall_cfg.svh"
`default_nettype none
module cog_fall_shutdown
    import cog_fall_pkg::*;
#(
    parameter int NSRC = 8,
    parameter int NSD  = 4
) (
    input  wire logic            sys_clk,        // System clock
    input  wire logic            nrst,           // Async reset, low
    input  wire logic [7:0]      s_axi_awaddr,   // Write address
    input  wire logic            s_axi_awvalid,  // Write address valid
    output logic                 s_axi_awready,  // Write address ready
    input  wire logic [31:0]     s_axi_wdata,    // Write data
    input  wire logic [3:0]      s_axi_wstrb,    // Write strobes
    input  wire logic            s_axi_wvalid,   // Write data valid
    output logic                 s_axi_wready,   // Write data ready
    output logic [1:0]           s_axi_bresp,    // Write response
    output logic                 s_axi_bvalid,   // Write response valid
    input  wire logic            s_axi_bready,   // Write response ready
    input  wire logic [7:0]      s_axi_araddr,   // Read address
    input  wire logic            s_axi_arvalid,  // Read address valid
    output logic                 s_axi_arready,  // Read address ready
    output logic [31:0]          s_axi_rdata,    // Read data
    output logic [1:0]           s_axi_rresp,    // Read response
    output logic                 s_axi_rvalid,   // Read data valid
    input  wire logic            s_axi_rready,   // Read data ready
    input  wire logic [NSRC-1:0] fall_src,       // Falling event sources
    input  wire logic [NSD-1:0]  sd_src,         // Shutdown sources
    input  wire logic            rising_event,   // Rising event pulse
    input  wire logic [3:0]      wave_in,        // Active-high d c b a
    output logic                 falling_event,  // Falling event pulse
    output logic                 shutdown_active,// Outputs overridden
    output logic [3:0]           out_pin,        // Pin levels d c b a
    output logic [3:0]           out_pin_oe,     // Pin drive enables
    output logic                 irq             // Interrupt level
);

    logic [7:0]      fall_src_en_ff, nxt_fall_src_en;
    logic [7:0]      fall_src_edge_sel_ff, nxt_fall_src_edge_sel;
    logic [7:0]      sd_ctrl_ff, nxt_sd_ctrl;
    logic [NSD-1:0]  sd_src_en_ff, nxt_sd_src_en;
    logic [3:0]      polarity_ff, nxt_polarity;
    logic [5:0]      phase_ff, nxt_phase;
    logic [1:0]      irq_stat_ff, nxt_irq_stat;
    logic [1:0]      irq_mask_ff, nxt_irq_mask;
    logic            aw_ok_ff, nxt_aw_ok;
    logic            w_ok_ff, nxt_w_ok;
    logic [7:0]      awaddr_ff, nxt_awaddr;
    logic [31:0]     wdata_ff, nxt_wdata;
    logic [3:0]      wstrb_ff, nxt_wstrb;
    logic            bvalid_ff, nxt_bvalid;
    logic [1:0]      bresp_ff, nxt_bresp;
    logic            rvalid_ff, nxt_rvalid;
    logic [31:0]     rdata_ff, nxt_rdata;
    logic [1:0]      rresp_ff, nxt_rresp;
    logic [NSRC-1:0] src_prev_ff;
    dly_state_t      dly_ff, nxt_dly;
    logic [5:0]      dly_cnt_ff, nxt_dly_cnt;
    logic            fall_ev_ff, nxt_fall_ev;
    logic            active_ff, nxt_active;
    pin_drive_t      drive_ff, nxt_drive;

    logic [NSRC-1:0] edge_hit, level_hit;
    logic            any_edge, any_level, dly_done, sd_req, wr_go;
    logic            wr_ctrl;

    // Per-source qualification
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_src
            assign edge_hit[gi]  = fall_src_en_ff[gi] &
                                   fall_src_edge_sel_ff[gi] &
                                   src_prev_ff[gi] & ~fall_src[gi];
            assign level_hit[gi] = fall_src_en_ff[gi] &
                                   ~fall_src_edge_sel_ff[gi] &
                                   ~fall_src[gi];
        end
    endgenerate

    assign any_edge  = |edge_hit;
    assign any_level = |level_hit;
    assign sd_req    = |(sd_src_en_ff & ~sd_src);
    assign dly_done  = (dly_ff == DLY_RUN) && (dly_cnt_ff == '0);
    assign wr_go     = aw_ok_ff && w_ok_ff && !bvalid_ff;
    assign wr_ctrl   = wr_go && (awaddr_ff == `ADDR_SD_CTRL) && wstrb_ff[0];

    // Phase delay for edge-mode events
    always_comb begin
        nxt_dly     = dly_ff;
        nxt_dly_cnt = dly_cnt_ff;
        case (dly_ff)
            DLY_IDLE: begin
                if (any_edge) begin
                    nxt_dly     = DLY_RUN;
                    nxt_dly_cnt = phase_ff;
                end
            end
            DLY_RUN: begin
                if (dly_cnt_ff == '0) begin
                    nxt_dly = any_edge ? DLY_RUN : DLY_IDLE;
                    nxt_dly_cnt = phase_ff;
                end else begin
                    nxt_dly_cnt = dly_cnt_ff - 6'h01;
                end
            end
            default: nxt_dly = DLY_IDLE;
        endcase
        nxt_fall_ev = any_level | dly_done;
    end

    // Shutdown state and pin override
    always_comb begin
        logic st;
        logic [1:0] code;
        st   = sd_ctrl_ff[`SD_STATUS_BIT];
        code = 2'h0;
        if (wr_ctrl) begin
            if (wdata_ff[`SD_STATUS_BIT])
                st = 1'b1;
            else if (!sd_req)
                st = 1'b0;
        end
        if (st && !sd_req && sd_ctrl_ff[`SD_RESTART_BIT] && !wr_ctrl)
            st = 1'b0;
        if (sd_req)
            st = 1'b1;
        nxt_sd_ctrl = sd_ctrl_ff;
        if (wr_ctrl)
            nxt_sd_ctrl = wdata_ff[7:0] & `SD_CTRL_IMPL;
        nxt_sd_ctrl[`SD_STATUS_BIT] = st;
        nxt_active = active_ff;
        if (st)
            nxt_active = 1'b1;
        else if (rising_event)
            nxt_active = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (i == 0 || i == 2)
                code = sd_ctrl_ff[`SD_AC_HI:`SD_AC_LO];
            else
                code = sd_ctrl_ff[`SD_BD_HI:`SD_BD_LO];
            nxt_drive.oe[i]    = 1'b1;
            nxt_drive.level[i] = wave_in[i] ^ polarity_ff[i];
            if (nxt_active) begin
                case (code)
                    `OVR_HIGH: nxt_drive.level[i] = 1'b1;
                    `OVR_LOW:  nxt_drive.level[i] = 1'b0;
                    `OVR_HIZ: begin
                        nxt_drive.level[i] = 1'b0;
                        nxt_drive.oe[i]    = 1'b0;
                    end
                    default:   nxt_drive.level[i] = polarity_ff[i];
                endcase
            end
        end
    end

    // AXI4-Lite slave and register file
    always_comb begin
        logic [31:0] rd;
        rd = 32'h0000_0000;
        nxt_aw_ok  = aw_ok_ff;
        nxt_w_ok   = w_ok_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata  = wdata_ff;
        nxt_wstrb  = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp  = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        nxt_fall_src_en       = fall_src_en_ff;
        nxt_fall_src_edge_sel = fall_src_edge_sel_ff;
        nxt_sd_src_en  = sd_src_en_ff;
        nxt_polarity   = polarity_ff;
        nxt_phase      = phase_ff;
        nxt_irq_mask   = irq_mask_ff;
        nxt_irq_stat   = irq_stat_ff;
        if (s_axi_awvalid && !aw_ok_ff) begin
            nxt_aw_ok  = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_ok_ff) begin
            nxt_w_ok  = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (wr_go) begin
            nxt_aw_ok  = 1'b0;
            nxt_w_ok   = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = `RESP_OKAY;
            if (awaddr_ff == `ADDR_FALL_EN) begin
                if (wstrb_ff[0]) nxt_fall_src_en = wdata_ff[7:0];
            end else if (awaddr_ff == `ADDR_FALL_MODE) begin
                if (wstrb_ff[0]) nxt_fall_src_edge_sel = wdata_ff[7:0];
            end else if (awaddr_ff == `ADDR_SD_CTRL) begin
                nxt_bresp = `RESP_OKAY;
            end else if (awaddr_ff == `ADDR_SD_SRC_EN) begin
                if (wstrb_ff[0]) nxt_sd_src_en = wdata_ff[NSD-1:0];
            end else if (awaddr_ff == `ADDR_POLARITY) begin
                if (wstrb_ff[0]) nxt_polarity = wdata_ff[3:0];
            end else if (awaddr_ff == `ADDR_PHASE) begin
                if (wstrb_ff[0]) nxt_phase = wdata_ff[5:0];
            end else if (awaddr_ff == `ADDR_IRQ_STAT) begin
                if (wstrb_ff[0]) nxt_irq_stat = irq_stat_ff & ~wdata_ff[1:0];
            end else if (awaddr_ff == `ADDR_IRQ_MASK) begin
                if (wstrb_ff[0]) nxt_irq_mask = wdata_ff[1:0];
            end else begin
                nxt_bresp = `RESP_SLVERR;
            end
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        // Hardware set wins over software clear
        if (fall_ev_ff)
            nxt_irq_stat[`IRQ_FALL_BIT] = 1'b1;
        if (nxt_active && !active_ff)
            nxt_irq_stat[`IRQ_SD_BIT] = 1'b1;
        if (s_axi_arvalid && !rvalid_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = `RESP_OKAY;
            if (s_axi_araddr == `ADDR_FALL_EN)
                rd[7:0] = fall_src_en_ff;
            else if (s_axi_araddr == `ADDR_FALL_MODE)
                rd[7:0] = fall_src_edge_sel_ff;
            else if (s_axi_araddr == `ADDR_SD_CTRL)
                rd[7:0] = sd_ctrl_ff & `SD_CTRL_IMPL;
            else if (s_axi_araddr == `ADDR_SD_SRC_EN)
                rd[NSD-1:0] = sd_src_en_ff;
            else if (s_axi_araddr == `ADDR_POLARITY)
                rd[3:0] = polarity_ff;
            else if (s_axi_araddr == `ADDR_PHASE)
                rd[5:0] = phase_ff;
            else if (s_axi_araddr == `ADDR_IRQ_STAT)
                rd[1:0] = irq_stat_ff;
            else if (s_axi_araddr == `ADDR_IRQ_MASK)
                rd[1:0] = irq_mask_ff;
            else
                nxt_rresp = `RESP_SLVERR;
            nxt_rdata = rd;
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fall_src_en_ff       <= `RST_BYTE;
            fall_src_edge_sel_ff <= `RST_BYTE;
            sd_ctrl_ff           <= `RST_BYTE;
            sd_src_en_ff         <= '0;
            polarity_ff          <= `RST_NIB;
            phase_ff             <= `RST_PHASE;
            irq_stat_ff          <= 2'h0;
            irq_mask_ff          <= 2'h0;
            aw_ok_ff             <= 1'b0;
            w_ok_ff              <= 1'b0;
            awaddr_ff            <= 8'h00;
            wdata_ff             <= 32'h0000_0000;
            wstrb_ff             <= 4'h0;
            bvalid_ff            <= 1'b0;
            bresp_ff             <= `RESP_OKAY;
            rvalid_ff            <= 1'b0;
            rdata_ff             <= 32'h0000_0000;
            rresp_ff             <= `RESP_OKAY;
            src_prev_ff          <= '0;
            dly_ff               <= DLY_IDLE;
            dly_cnt_ff           <= `RST_PHASE;
            fall_ev_ff           <= 1'b0;
            active_ff            <= 1'b0;
            drive_ff             <= '0;
        end else begin
            fall_src_en_ff       <= nxt_fall_src_en;
            fall_src_edge_sel_ff <= nxt_fall_src_edge_sel;
            sd_ctrl_ff           <= nxt_sd_ctrl;
            sd_src_en_ff         <= nxt_sd_src_en;
            polarity_ff          <= nxt_polarity;
            phase_ff             <= nxt_phase;
            irq_stat_ff          <= nxt_irq_stat;
            irq_mask_ff          <= nxt_irq_mask;
            aw_ok_ff             <= nxt_aw_ok;
            w_ok_ff              <= nxt_w_ok;
            awaddr_ff            <= nxt_awaddr;
            wdata_ff             <= nxt_wdata;
            wstrb_ff             <= nxt_wstrb;
            bvalid_ff            <= nxt_bvalid;
            bresp_ff             <= nxt_bresp;
            rvalid_ff            <= nxt_rvalid;
            rdata_ff             <= nxt_rdata;
            rresp_ff             <= nxt_rresp;
            src_prev_ff          <= fall_src;
            dly_ff               <= nxt_dly;
            dly_cnt_ff           <= nxt_dly_cnt;
            fall_ev_ff           <= nxt_fall_ev;
            active_ff            <= nxt_active;
            drive_ff             <= nxt_drive;
        end
    end

    assign s_axi_awready   = !aw_ok_ff;
    assign s_axi_wready    = !w_ok_ff;
    assign s_axi_bvalid    = bvalid_ff;
    assign s_axi_bresp     = bresp_ff;
    assign s_axi_arready   = !rvalid_ff;
    assign s_axi_rvalid    = rvalid_ff;
    assign s_axi_rdata     = rdata_ff;
    assign s_axi_rresp     = rresp_ff;
    assign falling_event   = fall_ev_ff;
    assign shutdown_active = active_ff;
    assign out_pin         = drive_ff.level;
    assign out_pin_oe      = drive_ff.oe;
    assign irq             = |(irq_stat_ff & irq_mask_ff);

    property p_disabled_silent;
        @(posedge sys_clk) disable iff (!nrst)
        (fall_src_en_ff == 8'h00 && dly_ff == DLY_IDLE) |=> !fall_ev_ff;
    endproperty
    a_disabled_silent: assert property (p_disabled_silent)
        else $error("disabled sources produced a falling event");

    property p_level_now;
        @(posedge sys_clk) disable iff (!nrst)
        |(fall_src_en_ff & ~fall_src_edge_sel_ff & ~fall_src) |=> fall_ev_ff;
    endproperty
    a_level_now: assert property (p_level_now)
        else $error("low level did not fire falling event next cycle");

    property p_edge_delay;
        @(posedge sys_clk) disable iff (!nrst)
        (dly_ff == DLY_IDLE && any_edge && phase_ff == 6'h05)
            |=> !dly_done [*5] ##1 dly_done ##1 fall_ev_ff;
    endproperty
    a_edge_delay: assert property (p_edge_delay)
        else $error("edge event not delayed by phase count");

    property p_mode_needs_en;
        @(posedge sys_clk) disable iff (!nrst)
        (fall_src_en_ff == 8'h00 && fall_src_edge_sel_ff != 8'h00
            && dly_ff == DLY_IDLE) |=> dly_ff == DLY_IDLE && !fall_ev_ff;
    endproperty
    a_mode_needs_en: assert property (p_mode_needs_en)
        else $error("mode bit acted without enable");

    property p_sd_sets_status;
        @(posedge sys_clk) disable iff (!nrst)
        sd_req |=> sd_ctrl_ff[`SD_STATUS_BIT] && active_ff;
    endproperty
    a_sd_sets_status: assert property (p_sd_sets_status)
        else $error("shutdown source did not enter shutdown");

    property p_no_restart_holds;
        @(posedge sys_clk) disable iff (!nrst)
        (sd_ctrl_ff[`SD_STATUS_BIT] && !sd_ctrl_ff[`SD_RESTART_BIT]
            && !wr_ctrl) |=> sd_ctrl_ff[`SD_STATUS_BIT];
    endproperty
    a_no_restart_holds: assert property (p_no_restart_holds)
        else $error("status cleared without auto restart");

    property p_restart_clears;
        @(posedge sys_clk) disable iff (!nrst)
        (sd_ctrl_ff[`SD_STATUS_BIT] && sd_ctrl_ff[`SD_RESTART_BIT]
            && !sd_req && !wr_ctrl) |=> !sd_ctrl_ff[`SD_STATUS_BIT];
    endproperty
    a_restart_clears: assert property (p_restart_clears)
        else $error("auto restart did not clear status");

    property p_exit_on_rise;
        @(posedge sys_clk) disable iff (!nrst)
        (active_ff && !sd_ctrl_ff[`SD_STATUS_BIT] && !sd_req && !wr_ctrl
            && rising_event) |=> !active_ff;
    endproperty
    a_exit_on_rise: assert property (p_exit_on_rise)
        else $error("shutdown not left on rising event");

    property p_bd_low;
        @(posedge sys_clk) disable iff (!nrst)
        (active_ff && $stable(active_ff)
            && $past(sd_ctrl_ff[`SD_BD_HI:`SD_BD_LO]) == `OVR_LOW)
            |-> out_pin[1] == 1'b0 && out_pin[3] == 1'b0 && out_pin_oe[1];
    endproperty
    a_bd_low: assert property (p_bd_low)
        else $error("B/D not forced low in shutdown");

    property p_ac_inactive;
        @(posedge sys_clk) disable iff (!nrst)
        (active_ff && $stable(active_ff)
            && $past(sd_ctrl_ff[`SD_AC_HI:`SD_AC_LO]) == `OVR_INACTIVE)
            |-> out_pin[0] == $past(polarity_ff[0]);
    endproperty
    a_ac_inactive: assert property (p_ac_inactive)
        else $error("inactive level ignores polarity");

    property p_ctrl_low_zero;
        @(posedge sys_clk) disable iff (!nrst)
        sd_ctrl_ff[1:0] == 2'h0;
    endproperty
    a_ctrl_low_zero: assert property (p_ctrl_low_zero)
        else $error("unimplemented control bits set");

    property p_polarity_run;
        @(posedge sys_clk) disable iff (!nrst)
        (!nxt_active) |=> out_pin == ($past(wave_in) ^ $past(polarity_ff));
    endproperty
    a_polarity_run: assert property (p_polarity_run)
        else $error("running output ignores polarity");

endmodule
`default_nettype wire

// ===== cog_src_model.sv
`default_nettype none
module cog_src_model (
    input  wire logic       sys_clk,      // Clock
    input  wire logic       nrst,         // Reset, low
    input  wire logic [7:0] fall_cmd,     // Wanted source levels
    input  wire logic [3:0] sd_cmd,       // Wanted shutdown levels
    input  wire logic       rise_cmd,     // Rising request level
    output logic      [7:0] fall_src,     // Falling sources
    output logic      [3:0] sd_src,       // Shutdown sources
    output logic            rising_event, // One-cycle pulse
    output logic      [3:0] wave_in       // Waveforms
);
    timeunit 1ns;
    timeprecision 1ns;
    logic rise_q;
    // Peripherals idle high; waveforms change every cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            {fall_src, sd_src, rising_event, rise_q} <= 14'h3FFC;
            wave_in <= 4'h0;
        end else begin
            fall_src <= fall_cmd;
            sd_src <= sd_cmd;
            rising_event <= rise_cmd & ~rise_q;
            rise_q <= rise_cmd;
            wave_in <= wave_in + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== test_complementary_gen_fall_and_shutdown.sv
`include "cog_fall_cfg.svh"
`default_nettype none
module test_complementary_gen_fall_and_shutdown;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'h0, nrst = 1'h0, rise_cmd = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, fall_src;
    logic [7:0]  fall_cmd = 8'hFF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
    logic [3:0]  s_axi_wstrb = 4'hF, sd_cmd = 4'hF, sd_src, wave_in;
    logic [3:0]  out_pin, out_pin_oe, ep, eo;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, k;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic        rising_event, falling_event, shutdown_active;
    int          fails = 0, checks_done = 0, dl, d0, d5;
    // Rows: enable, mode, source levels, event expected in bit 0
    logic [31:0] rows [12] = '{32'h0100FE01, 32'h0200FD01, 32'h0400FB01,
        32'h0800F701, 32'h1000EF01, 32'h2000DF01, 32'h4000BF01,
        32'h80007F01, 32'h80807F01, 32'h0101FE01, 32'h00FF0000,
        32'hFE00FE00};
    cog_src_model i_cog_src_model (.sys_clk, .nrst, .fall_cmd, .sd_cmd,
        .rise_cmd, .fall_src, .sd_src, .rising_event, .wave_in);
    cog_fall_shutdown i_cog_fall_shutdown (.sys_clk, .nrst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fall_src,
        .sd_src, .rising_event, .wave_in, .falling_event, .shutdown_active,
        .out_pin, .out_pin_oe, .irq);
    always #20 sys_clk = ~sys_clk;
    task automatic test_done();
        if (fails == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, d);
        logic ta, tw, tr, db;
        db = 1'h0;
        @(posedge sys_clk);
        if (w) begin
            {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        end else begin
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
        end
        for (int n = 0; n < 50 && !db; n++) begin
            @(negedge sys_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tr = s_axi_arvalid & s_axi_arready;
            db = w ? s_axi_bvalid === 1'h1 : s_axi_rvalid === 1'h1;
            r = w ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            @(posedge sys_clk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            if (tr) s_axi_arvalid <= 1'h0;
            if (db) {s_axi_bready, s_axi_rready} <= 2'h0;
        end
        @(negedge sys_clk);
        if (!db) begin
            chk("timeout", 32'h0, 32'h1);
            test_done();
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        xfer(1'h1, a, d);
        chk("bresp", 32'(r), 32'(`RESP_OKAY));
    endtask
    task automatic rd_chk(input logic [7:0] a, e);
        xfer(1'h0, a, 8'h00);
        chk($sformatf("reg_%h", a), q, {24'h0, e});
    endtask
    task automatic rst_chk();
        rd_chk(`ADDR_FALL_EN, 8'h00);
        rd_chk(`ADDR_FALL_MODE, 8'h00);
        rd_chk(`ADDR_SD_CTRL, 8'h00);
    endtask
    task automatic lat(input logic [7:0] m, output int d);
        wr(`ADDR_FALL_MODE, m);
        fall_cmd <= 8'hFE;
        for (d = 0; d < 60 && falling_event !== 1'h1; d++)
            @(negedge sys_clk);
        if (d == 60) begin
            chk("lat_timeout", 32'h0, 32'h1);
            test_done();
        end
        fall_cmd <= 8'hFF;
        repeat (60) @(negedge sys_clk);
    endtask
    task automatic rise();
        rise_cmd <= 1'h1;
        repeat (2) @(negedge sys_clk);
        rise_cmd <= 1'h0;
        repeat (4) @(negedge sys_clk);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'h1;
        rst_chk();
        foreach (rows[i]) begin
            wr(`ADDR_FALL_EN, rows[i][31:24]);
            wr(`ADDR_FALL_MODE, rows[i][23:16]);
            fall_cmd <= rows[i][15:8];
            q = 32'h0;
            repeat (8) begin
                @(negedge sys_clk);
                q[0] = q[0] | (falling_event === 1'h1);
            end
            chk("event", q, 32'(rows[i][0]));
            fall_cmd <= 8'hFF;
            repeat (8) @(negedge sys_clk);
        end
        chk("irq", 32'(irq), 32'h0);
        rd_chk(`ADDR_IRQ_STAT, 8'h01);
        wr(`ADDR_IRQ_MASK, 8'h01);
        chk("irq", 32'(irq), 32'h1);
        wr(`ADDR_IRQ_STAT, 8'h01);
        chk("irq", 32'(irq), 32'h0);
        xfer(1'h1, 8'h20, 8'h55);
        chk("bresp", 32'(r), 32'(`RESP_SLVERR));
        rd_chk(8'h20, 8'h00);
        chk("rresp", 32'(r), 32'(`RESP_SLVERR));
        wr(`ADDR_FALL_EN, 8'h01);
        lat(8'h00, dl);
        lat(8'h01, d0);
        wr(`ADDR_PHASE, 8'h05);
        lat(8'h01, d5);
        chk("level_lat", 32'(d0), 32'(dl + 1));
        chk("phase_lat", 32'(d5), 32'(d0 + 5));
        wr(`ADDR_POLARITY, 8'h05);
        wr(`ADDR_SD_SRC_EN, 8'h02);
        sd_cmd <= 4'h2;
        repeat (4) @(negedge sys_clk);
        chk("sd", 32'(shutdown_active), 32'h0);
        for (int c = 0; c < 4; c++) begin
            wr(`ADDR_SD_CTRL, {2'h0, c[1:0], 2'(3 - c), 2'h0});
            sd_cmd <= 4'hD;
            repeat (4) @(negedge sys_clk);
            for (int p = 0; p < 4; p++) begin
                k = p[0] ? c[1:0] : 2'(3 - c);
                ep[p] = k == 2'h3 || (k == 2'h0 && !p[0]);
                eo[p] = k != 2'h1;
            end
            chk("pin", 32'(out_pin), 32'(ep));
            chk("oe", 32'(out_pin_oe), 32'(eo));
            chk("sd", 32'(shutdown_active), 32'h1);
            sd_cmd <= 4'hF;
            rd_chk(`ADDR_SD_CTRL, {2'h2, c[1:0], 2'(3 - c), 2'h0});
            wr(`ADDR_SD_CTRL, 8'h00);
            rise();
            chk("sd", 32'(shutdown_active), 32'h0);
            chk("oe", 32'(out_pin_oe), 32'hF);
        end
        rd_chk(`ADDR_IRQ_STAT, 8'h03);
        wr(`ADDR_SD_CTRL, 8'h43);
        rd_chk(`ADDR_SD_CTRL, 8'h40);
        sd_cmd <= 4'hD;
        repeat (4) @(negedge sys_clk);
        rd_chk(`ADDR_SD_CTRL, 8'hC0);
        sd_cmd <= 4'hF;
        repeat (4) @(negedge sys_clk);
        rd_chk(`ADDR_SD_CTRL, 8'h40);
        chk("sd", 32'(shutdown_active), 32'h1);
        rise();
        chk("sd", 32'(shutdown_active), 32'h0);
        wr(`ADDR_SD_CTRL, 8'h80);
        repeat (3) @(negedge sys_clk);
        chk("sd", 32'(shutdown_active), 32'h1);
        @(posedge sys_clk);
        nrst <= 1'h0;
        @(posedge sys_clk);
        nrst <= 1'h1;
        rst_chk();
        test_done();
    end
endmodule
`default_nettype wire
